//--- hdl/vin_fault_response.sv
/*
 * Input-voltage supervision: thresholds, sample comparison, hybrid ratio
 * threshold indication and the programmable undervoltage fault response.
 * Assumes command writes, samples and control levels come from logic on
 * the same clock; the delay time unit arrives from its own register.
 */
`timescale 1ns/100ps
`default_nettype none

module vin_fault_response
    import vin_fault_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Command port
    input wire cmd_s cmd,
    input wire logic [7:0] rd_code,
    output logic [15:0] rd_data,
    // Measurement
    input wire logic sample_valid,
    input wire logic [15:0] vin_sample,
    // Delay time unit in system clocks
    input wire logic [15:0] unit_cycles,
    // Control
    input wire logic hybrid_ratio_enable,
    input wire logic commanded_on,
    input wire logic other_shutdown,
    input wire logic clear_faults,
    // Status
    output vin_flags_s flags,
    output logic hybrid_ratio_below,
    output logic out_enable,
    output logic fault_latched
);

    logic [15:0] input_overvolt_warn_threshold;
    logic [15:0] input_undervolt_warn_threshold;
    logic [15:0] input_undervolt_fault_threshold;
    logic [7:0] input_undervolt_fault_action;
    resp_state_e state;
    resp_state_e next_state;
    logic [2:0] retries_left;
    logic [2:0] next_retries;
    logic timer_start;
    logic timer_done;

    wire [1:0] act_code = input_undervolt_fault_action[ACT_MSB:ACT_LSB];
    wire [2:0] retry_code = input_undervolt_fault_action[RETRY_MSB:RETRY_LSB];
    wire [2:0] delay_code = input_undervolt_fault_action[DELAY_MSB:DELAY_LSB];

    // Register writes
    wire wr_ov = cmd.wr && (cmd.code == CMD_OV_WARN);
    wire wr_uvw = cmd.wr && (cmd.code == CMD_UV_WARN);
    wire wr_uvf = cmd.wr && (cmd.code == CMD_UV_FAULT);
    wire wr_act = cmd.wr && (cmd.code == CMD_UV_ACTION);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            input_overvolt_warn_threshold <= THRESH_RESET;
            input_undervolt_warn_threshold <= THRESH_RESET;
            input_undervolt_fault_threshold <= THRESH_RESET;
            input_undervolt_fault_action <= ACTION_RESET;
        end else begin
            if (wr_ov) input_overvolt_warn_threshold <= cmd.data; // [R1]
            if (wr_uvw) input_undervolt_warn_threshold <= cmd.data; // [R2]
            if (wr_uvf) input_undervolt_fault_threshold <= cmd.data; // [R3]
            if (wr_act) input_undervolt_fault_action <= cmd.data[7:0];
        end
    end

    // Read mux; unmapped codes read zero
    wire [15:0] next_rd_data =
        (rd_code == CMD_OV_WARN) ? input_overvolt_warn_threshold :
        (rd_code == CMD_UV_WARN) ? input_undervolt_warn_threshold :
        (rd_code == CMD_UV_FAULT) ? input_undervolt_fault_threshold :
        (rd_code == CMD_UV_ACTION) ? {8'h00, input_undervolt_fault_action} :
        16'h0000;

    // Sample comparison in a common fixed-point scale
    wire signed [47:0] vin_fx = linear_to_fixed(vin_sample);
    wire above_ov = vin_fx > linear_to_fixed(input_overvolt_warn_threshold);
    wire below_uvw = vin_fx < linear_to_fixed(input_undervolt_warn_threshold);
    wire below_uvf = vin_fx < linear_to_fixed(input_undervolt_fault_threshold);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            flags <= '0;
            hybrid_ratio_below <= 1'b0;
            rd_data <= 16'h0000;
        end else begin
            rd_data <= next_rd_data; // [R1] [R3]
            if (sample_valid) begin
                flags.ov_warn <= above_ov; // [R14]
                flags.uv_warn <= below_uvw; // [R14]
                flags.uv_fault <= below_uvf; // [R14]
                hybrid_ratio_below <= hybrid_ratio_enable && below_uvw; // [R2]
            end
        end
    end

    // Fault response
    wire uv_fault = flags.uv_fault;
    wire stop_all = !commanded_on || other_shutdown;
    wire [2:0] down_state_sel = (retry_code == RETRY_NONE) ? 3'h0 : 3'h1;

    always_comb begin
        next_state = state;
        next_retries = retries_left;
        timer_start = 1'b0;
        if (stop_all) begin
            next_state = ST_IDLE; // [R11] [R7]
        end else begin
            case (state)
                ST_IDLE: begin
                    if (uv_fault) begin
                        case (act_code)
                            ACT_CONTINUE: begin
                                next_state = ST_CONT; // [R5]
                                timer_start = 1'b1;
                            end
                            ACT_RETRY: begin
                                // Disable now, retry per field [R6] [R8]
                                next_state = (down_state_sel == 3'h0) ? ST_LATCH : ST_WAIT;
                                next_retries = retry_code;
                                timer_start = (down_state_sel != 3'h0);
                            end
                            ACT_LATCH: next_state = ST_LATCH; // [R7]
                            default: next_state = ST_IDLE; // [R4]
                        endcase
                    end
                end
                ST_CONT: begin
                    if (timer_done && uv_fault) begin
                        next_state = (down_state_sel == 3'h0) ? ST_LATCH : ST_WAIT; // [R5]
                        next_retries = retry_code;
                        timer_start = (down_state_sel != 3'h0);
                    end else if (timer_done) begin
                        next_state = ST_IDLE;
                    end
                end
                ST_WAIT: begin
                    if (timer_done && retries_left == 3'h0) begin
                        next_state = ST_LATCH; // [R9]
                    end else if (timer_done) begin
                        // Each attempt spends one retry; forever never runs out
                        if (retries_left != RETRY_FOREVER) begin
                            next_retries = retries_left - 3'h1; // [R15] [R11]
                        end
                        timer_start = 1'b1; // [R10]
                        next_state = ST_TRY;
                    end
                end
                ST_TRY: begin
                    if (uv_fault) begin
                        next_state = ST_WAIT; // [R15]
                    end else if (timer_done) begin
                        next_state = ST_IDLE;
                    end
                end
                ST_LATCH: begin
                    if (clear_faults) next_state = ST_IDLE; // [R7]
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    wire next_run = (next_state == ST_IDLE) || (next_state == ST_CONT) ||
        (next_state == ST_TRY);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            retries_left <= 3'h0;
            out_enable <= 1'b0;
            fault_latched <= 1'b0;
        end else begin
            state <= next_state;
            retries_left <= next_retries;
            out_enable <= next_run && !stop_all; // [R6] [R8]
            fault_latched <= (next_state == ST_LATCH); // [R7]
        end
    end

    vin_delay_timer u_timer (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .start(timer_start),
        .delay_code(delay_code),
        .unit_cycles(unit_cycles),
        .done(timer_done)
    );

    ov_compare_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (sample_valid && above_ov) |=> flags.ov_warn) // [R14]
        else $error("overvoltage warning missed");

    uv_fault_flag_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (sample_valid && !below_uvf) |=> !flags.uv_fault) // [R3]
        else $error("undervoltage fault flag false");

    ignore_fault_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == ST_IDLE && act_code == ACT_IGNORE && !stop_all) |=>
            (state == ST_IDLE && out_enable)) // [R4]
        else $error("ignored fault changed state");

    continue_run_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == ST_IDLE && uv_fault && act_code == ACT_CONTINUE && !stop_all)
            |=> (state == ST_CONT && out_enable)) // [R5]
        else $error("continue mode did not keep running");

    disable_now_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == ST_IDLE && uv_fault && act_code == ACT_RETRY) |=> !out_enable) // [R6]
        else $error("output not disabled at once");

    no_retry_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == ST_IDLE && uv_fault && act_code == ACT_RETRY &&
            retry_code == RETRY_NONE && !stop_all) |=> state == ST_LATCH) // [R8]
        else $error("zero retries did not latch off");

    latch_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == ST_LATCH && !clear_faults && !stop_all) |=>
            (state == ST_LATCH && !out_enable)) // [R7]
        else $error("latched fault released early");

    retries_out_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == ST_WAIT && timer_done && retries_left == 3'h0 && !stop_all)
            |=> (fault_latched && !out_enable)) // [R9]
        else $error("exhausted retries did not latch");

    retry_forever_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == ST_WAIT && timer_done && retries_left == RETRY_FOREVER && !stop_all)
            |=> (state == ST_TRY && retries_left == RETRY_FOREVER)) // [R11]
        else $error("continuous retry stopped");

    retry_count_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == ST_WAIT && timer_done && retries_left != 3'h0 &&
            retries_left != RETRY_FOREVER && !stop_all) |=>
            retries_left == $past(retries_left) - 3'h1) // [R15]
        else $error("retry count not decremented");

    spacing_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == ST_WAIT && timer_done && retries_left != 3'h0 && !stop_all)
            |-> timer_start) // [R10]
        else $error("attempt spacing not restarted");

    cont_recover_c: cover property (@(posedge clk_sys) disable iff (!nrst)
        state == ST_CONT ##[1:1000] state == ST_IDLE);
    retry_try_c: cover property (@(posedge clk_sys) disable iff (!nrst)
        state == ST_WAIT ##[1:1000] state == ST_TRY);
    latch_c: cover property (@(posedge clk_sys) disable iff (!nrst)
        state == ST_TRY ##[1:1000] state == ST_LATCH);

endmodule

`default_nettype wire

//--- hdl/vin_fault_pkg.sv
/*
 * Shared constants and types for input-voltage supervision and the
 * undervoltage fault response. Assumes a single 100 MHz system clock.
 */
// Functional notes
// R1: Hold 16-bit linear overvoltage warning threshold.
// R2: Undervoltage warning also sets hybrid ratio threshold.
// R3: Hold 16-bit linear undervoltage fault threshold.
// R4: Action 00 ignores the fault.
// R5: Action 01 runs for delay, then retries.
// R6: Action 10 disables at once, then retries.
// R7: Action 11 stays off until cleared.
// R8: Retry 000 never restarts; stays off.
// R9: Retry 1..6 attempts, then off until cleared.
// R10: Attempt spacing is multiplier times time unit.
// R11: Retry 111 retries until commanded off.
// R12: Delay field selects multiplier two to code.
// R13: Delay unit length comes from time-unit register.
// R14: Compare samples and raise warning or fault flags.
// R15: Failed attempt decrements remaining retry count.
package vin_fault_pkg;

    // Command codes of the thresholds and response byte
    localparam logic [7:0] CMD_OV_WARN = 8'h57;
    localparam logic [7:0] CMD_UV_WARN = 8'h58;
    localparam logic [7:0] CMD_UV_FAULT = 8'h59;
    localparam logic [7:0] CMD_UV_ACTION = 8'h5A;
    // Codes owned by neighbouring blocks: special options, delay time unit
    localparam logic [7:0] CMD_SPECIAL_OPTIONS = 8'hE0;
    localparam logic [7:0] CMD_TIME_UNIT = 8'hD2;

    // Field positions of the response byte
    localparam int ACT_MSB = 7;
    localparam int ACT_LSB = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int DELAY_MSB = 2;
    localparam int DELAY_LSB = 0;

    // Response action codes
    localparam logic [1:0] ACT_IGNORE = 2'h0;
    localparam logic [1:0] ACT_CONTINUE = 2'h1;
    localparam logic [1:0] ACT_RETRY = 2'h2;
    localparam logic [1:0] ACT_LATCH = 2'h3;

    // Retry codes
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    // Reset values
    localparam logic [15:0] THRESH_RESET = 16'h0000;
    localparam logic [7:0] ACTION_RESET = 8'h00;

    // Linear format: signed 5-bit exponent, signed 11-bit mantissa
    localparam int EXP_MSB = 15;
    localparam int EXP_LSB = 11;
    localparam int MANT_MSB = 10;
    localparam int EXP_BIAS = 16;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CONT,
        ST_WAIT,
        ST_TRY,
        ST_LATCH
    } resp_state_e;

    typedef struct packed {
        logic wr;
        logic [7:0] code;
        logic [15:0] data;
    } cmd_s;

    typedef struct packed {
        logic ov_warn;
        logic uv_warn;
        logic uv_fault;
    } vin_flags_s;

    // Linear value scaled by two to the bias, as a signed fixed-point number
    function automatic logic signed [47:0] linear_to_fixed(input logic [15:0] v);
        logic signed [4:0] e;
        logic signed [10:0] m;
        logic signed [47:0] m48;
        int sh;
        e = signed'(v[EXP_MSB:EXP_LSB]);
        m = signed'(v[MANT_MSB:0]);
        m48 = 48'(m);
        sh = int'(e) + EXP_BIAS;
        return m48 <<< sh;
    endfunction

endpackage

//--- hdl/vin_delay_timer.sv
/*
 * Delay timer for the fault response: counts a programmed number of time
 * units, each unit a programmed number of system clocks.
 * Assumes start is a one-cycle pulse from the same clock domain.
 */
`timescale 1ns/100ps
`default_nettype none

module vin_delay_timer
    import vin_fault_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Control
    input wire logic start,
    input wire logic [2:0] delay_code,
    input wire logic [15:0] unit_cycles,
    // Expiry
    output logic done
);

    logic [15:0] cyc;
    logic [7:0] units;
    logic running;
    wire [15:0] unit_eff = (unit_cycles == 16'h0000) ? 16'h0001 : unit_cycles;
    wire [7:0] units_load = (8'h01 << delay_code) - 8'h01;
    wire cyc_zero = (cyc == 16'h0000);
    wire last = running && cyc_zero && (units == 8'h00);

    // Expiry is seen in the last counted cycle, so start-to-start spacing is exact
    assign done = last;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cyc <= 16'h0000;
            units <= 8'h00;
            running <= 1'b0;
        end else begin
            if (start) begin
                // Unit count and length set the total [R12] [R13]
                cyc <= unit_eff - 16'h0001;
                units <= units_load;
                running <= 1'b1;
            end else if (last) begin
                running <= 1'b0;
            end else if (running && cyc_zero) begin
                units <= units - 8'h01;
                cyc <= unit_eff - 16'h0001;
            end else if (running) begin
                cyc <= cyc - 16'h0001;
            end
        end
    end

    property one_unit_p;
        @(posedge clk_sys) disable iff (!nrst)
        (start && delay_code == 3'h0 && unit_cycles == 16'h0003) |->
            ##1 !done [*2] ##1 done;
    endproperty
    unit_length_a: assert property (one_unit_p) // [R13]
        else $error("delay unit length wrong");

    mult_two_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (start && delay_code == 3'h1 && unit_cycles == 16'h0002) |->
            ##1 !done [*3] ##1 done) // [R12]
        else $error("delay multiplier wrong");

endmodule

`default_nettype wire

//--- bench/pmbus_host_model.sv
/*
 * Behavioural host that writes the limits and the response byte, reads
 * them back, and drives on/off and fault clear.
 * Assumes the block samples on the rising edge; the host moves on falling.
 */
`timescale 1ns/100ps
`default_nettype none

module pmbus_host_model
    import vin_fault_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Command and read ports
    output var cmd_s cmd,
    output var logic [7:0] rd_code,
    input wire logic [15:0] rd_data,
    // On/off and fault clear
    output var logic commanded_on,
    output var logic clear_faults
);
    initial begin
        cmd = '0;
        rd_code = 8'h00;
        commanded_on = 1'b0;
        clear_faults = 1'b0;
    end

    // Idle command fields show the inverse of the last word, never a copy
    task automatic write_cmd(input logic [7:0] code, input logic [15:0] data);
        @(negedge clk_sys);
        cmd <= '{wr: 1'b1, code: code, data: data};
        @(negedge clk_sys);
        cmd <= '{wr: 1'b0, code: ~code, data: ~data};
    endtask

    task automatic read_cmd(input logic [7:0] code, output logic [15:0] data);
        @(negedge clk_sys);
        rd_code <= code;
        @(negedge clk_sys);
        data = rd_data;
    endtask

    // Off-then-on and a fault clear both release a latched output
    task automatic set_on(input logic v);
        @(negedge clk_sys);
        commanded_on <= v;
    endtask

    task automatic clear_pulse();
        @(negedge clk_sys);
        clear_faults <= 1'b1;
        @(negedge clk_sys);
        clear_faults <= 1'b0;
    endtask
endmodule

`default_nettype wire

//--- bench/vin_fault_response_tb.sv
/*
 * Self-checking bench for the input-voltage supervision block.
 * Assumes samples use exponent 0, so Linear values compare as integers.
 */
`timescale 1ns/100ps
`default_nettype none

module vin_fault_response_tb
    import vin_fault_pkg::*;
;
    localparam logic [15:0] OV = 16'h0200;
    localparam logic [15:0] UVW = 16'h0040;
    localparam logic [15:0] UVF = 16'h0020;
    localparam logic [15:0] GOOD = 16'h0100;
    localparam logic [15:0] BAD = 16'h0010;

    logic clk_sys, nrst, sample_valid, hybrid_ratio_enable, commanded_on, other_shutdown;
    logic clear_faults, hybrid_ratio_below, out_enable, fault_latched;
    cmd_s cmd;
    logic [7:0] rd_code;
    logic [15:0] rd_data, vin_sample, unit_cycles, lf, v, got;
    vin_flags_s flags;
    int errors, cmp_count, rises, gap, lows, nu, n;
    logic [7:0] codes [4] = '{CMD_OV_WARN, CMD_UV_WARN, CMD_UV_FAULT, CMD_UV_ACTION};

    vin_fault_response i_vin_fault_response (.clk_sys(clk_sys), .nrst(nrst), .cmd(cmd),
        .rd_code(rd_code), .rd_data(rd_data), .sample_valid(sample_valid),
        .vin_sample(vin_sample), .unit_cycles(unit_cycles),
        .hybrid_ratio_enable(hybrid_ratio_enable),
        .commanded_on(commanded_on), .other_shutdown(other_shutdown),
        .clear_faults(clear_faults), .flags(flags), .hybrid_ratio_below(hybrid_ratio_below),
        .out_enable(out_enable), .fault_latched(fault_latched));

    pmbus_host_model i_pmbus_host_model (.clk_sys(clk_sys), .cmd(cmd), .rd_code(rd_code),
        .rd_data(rd_data), .commanded_on(commanded_on), .clear_faults(clear_faults));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic send_sample(input logic [15:0] s);
        @(negedge clk_sys);
        sample_valid <= 1'b1;
        vin_sample <= s;
        @(negedge clk_sys);
        sample_valid <= 1'b0;
        vin_sample <= ~s;
    endtask

    // Counts rising edges of the output, the last rise-to-rise gap and low cycles
    task automatic observe(input int win);
        int last;
        logic prev;
        rises = 0;
        gap = 0;
        lows = 0;
        last = 0;
        prev = out_enable;
        for (int i = 0; i < win; i++) begin
            @(negedge clk_sys);
            if (out_enable === 1'b1 && prev !== 1'b1) begin
                if (rises > 0)
                    gap = i - last;
                last = i;
                rises++;
            end
            if (out_enable !== 1'b1)
                lows++;
            prev = out_enable;
        end
    endtask

    task automatic run_case(input logic [1:0] act, input int r, input int d, input int win);
        i_pmbus_host_model.set_on(1'b0);
        send_sample(GOOD);
        i_pmbus_host_model.set_on(1'b1);
        i_pmbus_host_model.write_cmd(CMD_UV_ACTION, {8'h00, act, 3'(r), 3'(d)});
        nu = (1 << d) * int'(unit_cycles);
        send_sample(BAD);
        observe(win);
    endtask

    initial begin
        #400us;
        $display("watchdog expired");
        errors++;
        give_verdict();
    end

    initial begin
        errors = 0;
        cmp_count = 0;
        nrst = 1'b0;
        sample_valid = 1'b0;
        vin_sample = 16'h0000;
        unit_cycles = 16'h0003;
        hybrid_ratio_enable = 1'b0;
        other_shutdown = 1'b0;
        lf = 16'h004C;
        repeat (12) @(negedge clk_sys);
        chk("out_enable in reset", 16'h0000, {15'h0, out_enable});
        nrst <= 1'b1;
        foreach (codes[i]) begin
            i_pmbus_host_model.read_cmd(codes[i], got);
            chk("reset value", 16'h0000, got);
        end
        i_pmbus_host_model.write_cmd(CMD_TIME_UNIT, 16'h1234);
        i_pmbus_host_model.write_cmd(CMD_OV_WARN, OV);
        i_pmbus_host_model.write_cmd(CMD_UV_WARN, UVW);
        i_pmbus_host_model.write_cmd(CMD_UV_FAULT, UVF);
        i_pmbus_host_model.write_cmd(CMD_UV_ACTION, 16'hAB3C);
        i_pmbus_host_model.read_cmd(CMD_OV_WARN, got);
        chk("ov warn limit", OV, got);
        i_pmbus_host_model.read_cmd(CMD_UV_WARN, got);
        chk("uv warn limit", UVW, got);
        i_pmbus_host_model.read_cmd(CMD_UV_FAULT, got);
        chk("uv fault limit", UVF, got);
        i_pmbus_host_model.read_cmd(CMD_UV_ACTION, got);
        chk("response byte", 16'h003C, got);
        i_pmbus_host_model.read_cmd(CMD_TIME_UNIT, got);
        chk("unmapped code", 16'h0000, got);
        i_pmbus_host_model.set_on(1'b1);
        i_pmbus_host_model.write_cmd(CMD_UV_ACTION, 16'h0000);
        for (int i = 0; i < 160; i++) begin
            lf = lfsr(lf);
            v = (i < 3) ? codes[i] == CMD_OV_WARN ? OV : (i == 1 ? UVW : UVF) : {6'h00, lf[9:0]};
            hybrid_ratio_enable <= lf[15];
            send_sample(v);
            chk("flags", {13'h0, v > OV, v < UVW, v < UVF}, {13'h0, flags});
            chk("hybrid ratio", {15'h0, lf[15] && v < UVW},
                {15'h0, hybrid_ratio_below});
        end
        run_case(ACT_IGNORE, 0, 0, 30);
        chk("ignore lows", 16'h0000, 16'(lows));
        run_case(ACT_LATCH, 3, 0, 30);
        chk("latch out", 16'h0000, {15'h0, out_enable});
        chk("latch flag", 16'h0001, {15'h0, fault_latched});
        send_sample(GOOD);
        i_pmbus_host_model.clear_pulse();
        repeat (3) @(negedge clk_sys);
        chk("cleared out", 16'h0001, {15'h0, out_enable});
        run_case(ACT_RETRY, 0, 1, 40);
        chk("no retry rises", 16'h0000, 16'(rises));
        chk("no retry latch", 16'h0001, {15'h0, fault_latched});
        for (int r = 1; r < 7; r++) begin
            unit_cycles <= 16'(2 + r % 2);
            run_case(ACT_RETRY, r, r % 3, 8 * 4 * 3 + 10);
            chk("attempts", 16'(r), 16'(rises));
            if (r > 1)
                chk("attempt spacing", 16'(nu), 16'(gap));
            chk("retry latch", 16'h0001, {15'h0, fault_latched});
        end
        run_case(ACT_RETRY, 7, 0, 12 * 3 + 10);
        chk("endless rises", 16'h0001, {15'h0, rises >= 8});
        chk("endless spacing", 16'(nu), 16'(gap));
        @(negedge clk_sys);
        other_shutdown <= 1'b1;
        repeat (3) @(negedge clk_sys);
        observe(20);
        chk("stopped lows", 16'h0014, 16'(lows));
        other_shutdown <= 1'b0;
        run_case(ACT_CONTINUE, 0, 2, 0);
        n = 0;
        while (n < 40 && out_enable === 1'b1) begin
            @(negedge clk_sys);
            n++;
        end
        // One extra cycle is the sample-to-state latency seen from the bench
        chk("continue time", 16'(nu + 1), 16'(n));
        repeat (3) @(negedge clk_sys);
        chk("continue latch", 16'h0001, {15'h0, fault_latched});
        give_verdict();
    end
endmodule

`default_nettype wire
